// >>> bench/far_side_model.sv
`timescale 1ns/10ps
module far_side_model (
  input wire scl_oe_n_in,
  input wire sda_oe_n_in,
  input wire hold_sda_low_in,
  input wire pin_two_set_in,
  input wire pin_three_set_in,
  output wire scl_line_out,
  output wire sda_line_out,
  output reg remote_pin_two_out,
  output reg remote_pin_three_out
);
  reg link_clk = 1'b0;
  initial
  begin
    remote_pin_two_out = 1'b1;
    remote_pin_three_out = 1'b0;
  end
  // Deserializer updates pin values on its own unrelated link clock
  // Phase offset keeps link edges clear of both system clock edges
  initial
  begin
    #130;
    forever #400 link_clk = ~link_clk;
  end
  always @(posedge link_clk)
  begin
    remote_pin_two_out <= pin_two_set_in;
    remote_pin_three_out <= pin_three_set_in;
  end
  // Both lines are pulled up: low while any party pulls them
  assign scl_line_out = scl_oe_n_in;
  assign sda_line_out = sda_oe_n_in & ~hold_sda_low_in;
endmodule

// >>> bench/gpio_i2c_cfg_asserts.sv
`timescale 1ns/10ps
module gpio_i2c_cfg_asserts #(
  parameter WDOG_SLOW_CYC = 2000,
  parameter RECOVER_HALF_CYC = 4
) (
  input wire clock_in,
  input wire rst_b_in,
  input wire reg_wr_in,
  input wire reg_remote_in,
  input wire reg_wr_refused_out,
  input wire remote_slave_req_in,
  input wire remote_slave_req_out,
  input wire sda_low_req_in,
  input wire sda_in,
  input wire sda_oe_n_out,
  input wire scl_oe_n_out,
  input wire bus_free_out,
  input wire bus_recovering_out
);
  // Length of the current SCL low phase
  reg [15:0] low_cnt_q;
  always @(posedge clock_in)
  begin
    if (!rst_b_in || scl_oe_n_out)
      low_cnt_q <= 16'h0000;
    else
      low_cnt_q <= low_cnt_q + 16'h0001;
  end
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);
  slave_pass_a: assert property (remote_slave_req_out == $past(remote_slave_req_in))
    else $error("slave request not passed");
  refuse_cause_a: assert property (reg_wr_refused_out |-> $past(reg_wr_in && reg_remote_in))
    else $error("refusal without remote write");
  local_ok_a: assert property ($past(reg_wr_in && !reg_remote_in) |-> !reg_wr_refused_out)
    else $error("local write refused");
  sda_min_delay_a: assert property (!sda_low_req_in [*6] ##1 sda_low_req_in |=> sda_oe_n_out [*2])
    else $error("sda pulled too early");
  sda_release_a: assert property (!sda_low_req_in [*8] |-> sda_oe_n_out)
    else $error("sda pulled without request");
  free_excl_a: assert property (bus_recovering_out |-> !bus_free_out)
    else $error("free during recovery");
  free_clear_a: assert property (bus_free_out && $changed(sda_in) |-> ##[1:5] !bus_free_out)
    else $error("free kept after activity");
  pulse_low_a: assert property ($rose(scl_oe_n_out) |-> low_cnt_q == RECOVER_HALF_CYC)
    else $error("scl low phase wrong length");
  scl_idle_a: assert property (!bus_recovering_out [*3] |-> scl_oe_n_out)
    else $error("scl pulled outside recovery");
  cover property ($rose(bus_free_out));
  cover property ($rose(bus_recovering_out));
  cover property (reg_wr_refused_out);
endmodule

bind gpio_i2c_cfg gpio_i2c_cfg_asserts #(.WDOG_SLOW_CYC(WDOG_SLOW_CYC),
  .RECOVER_HALF_CYC(RECOVER_HALF_CYC)) chk (.clock_in(clock_in), .rst_b_in(rst_b_in),
  .reg_wr_in(reg_wr_in), .reg_remote_in(reg_remote_in), .reg_wr_refused_out(reg_wr_refused_out),
  .remote_slave_req_in(remote_slave_req_in), .remote_slave_req_out(remote_slave_req_out),
  .sda_low_req_in(sda_low_req_in), .sda_in(sda_in), .sda_oe_n_out(sda_oe_n_out),
  .scl_oe_n_out(scl_oe_n_out), .bus_free_out(bus_free_out),
  .bus_recovering_out(bus_recovering_out));

// >>> bench/gpio_i2c_cfg_tb_top.sv
`timescale 1ns/10ps
module gpio_i2c_cfg_tb_top;
  reg clock_in = 1'b0, rst_b_in = 1'b0, wr = 1'b0, rem = 1'b0, sreq = 1'b0, lreq = 1'b0;
  reg hold = 1'b0, set2 = 1'b1, set3 = 1'b0, pad = 1'b0, last;
  reg [7:0] addr = 8'h00, wdata = 8'h00;
  wire [7:0] rdata;
  wire refused, r2, r3, p2, p2oe, p3, p3oe, p3v, sout, scl_l, sda_l, scl_oe, sda_oe, free, recov;
  wire sclo, sdao;
  wire p3in = p3oe ? pad : p3;
  integer miscompares = 0, compares = 0, cycles = 0, n, p, c;
  always #50 clock_in = ~clock_in;
  gpio_i2c_cfg #(.WDOG_SLOW_CYC(2000), .RECOVER_HALF_CYC(4)) dut (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .reg_wr_in(wr), .reg_remote_in(rem),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_wr_refused_out(refused), .remote_pin_two_in(r2), .remote_pin_three_in(r3),
    .general_pin_three_in(p3in), .general_pin_two_out(p2), .general_pin_two_oe_n_out(p2oe),
    .general_pin_three_out(p3), .general_pin_three_oe_n_out(p3oe),
    .general_pin_three_value_out(p3v), .remote_slave_req_in(sreq),
    .remote_slave_req_out(sout), .sda_low_req_in(lreq), .scl_in(scl_l), .sda_in(sda_l),
    .scl_out(sclo), .scl_oe_n_out(scl_oe), .sda_out(sdao), .sda_oe_n_out(sda_oe),
    .bus_free_out(free), .bus_recovering_out(recov));
  far_side_model far (.scl_oe_n_in(scl_oe), .sda_oe_n_in(sda_oe), .hold_sda_low_in(hold),
    .pin_two_set_in(set2), .pin_three_set_in(set3), .scl_line_out(scl_l),
    .sda_line_out(sda_l), .remote_pin_two_out(r2), .remote_pin_three_out(r3));
  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task check(input [7:0] seen, input [7:0] exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d, input r);
    @(negedge clock_in);
    wr = 1'b1;
    addr = a;
    wdata = d;
    rem = r;
    @(negedge clock_in);
    wr = 1'b0;
  endtask
  task rd_reg(input [7:0] a, input [7:0] exp);
    @(negedge clock_in);
    addr = a;
    @(negedge clock_in);
    check(rdata, exp);
  endtask
  task wait_cyc(input integer k);
    repeat (k) @(negedge clock_in);
  endtask
  // Counts cycles until free (0), recovery (1) or SDA pulled (2)
  task wait_for(input integer sel, input integer lim);
    n = 0;
    while (n < lim && !(sel == 0 ? free === 1'b1 : sel == 1 ? recov === 1'b1 : sda_oe === 1'b0))
    begin
      @(negedge clock_in);
      n = n + 1;
    end
  endtask
  task t_reset;
    rd_reg(8'h0e, 8'h35);
    rd_reg(8'h0f, 8'h00);
    rd_reg(8'h20, 8'h00);
    check({p3oe, p2oe}, 2'b10);
  endtask
  task t_pins;
    wr_reg(8'h0e, 8'h99, 1'b0);
    wait_cyc(2);
    check({p3oe, p3, p2oe, p2}, 4'b0101);
    set2 = 1'b1;
    wr_reg(8'h0e, 8'h55, 1'b0);
    wait_cyc(14);
    check({p3oe, p3, p2oe, p2}, 4'b0001);
    set2 = 1'b0;
    set3 = 1'b1;
    wait_cyc(14);
    check({p3oe, p3, p2oe, p2}, 4'b0100);
    wr_reg(8'h0e, 8'h30, 1'b0);
    pad = 1'b1;
    wait_cyc(5);
    check({p3oe, p3v, p2oe}, 3'b111);
  endtask
  task t_lock;
    sreq = 1'b1;
    wr_reg(8'h0f, 8'h04, 1'b0);
    wr_reg(8'h0e, 8'h00, 1'b1);
    check({refused, sout}, 2'b11);
    rd_reg(8'h0e, 8'h30);
    wr_reg(8'h0f, 8'h00, 1'b0);
    wr_reg(8'h0e, 8'h08, 1'b1);
    check(refused, 1'b0);
    rd_reg(8'h0e, 8'h08);
    check({p3oe, p2oe}, 2'b11);
    sreq = 1'b0;
  endtask
  task t_delay;
    for (c = 0; c < 4; c = c + 1)
    begin
      wr_reg(8'h0f, {3'h0, c[1:0], 3'h0}, 1'b0);
      lreq = 1'b1;
      wait_for(2, 20);
      // Sampling edge plus the nominal delay in whole periods, rounded down
      check(n, (350 + 50 * c) / 100 + 1);
      lreq = 1'b0;
      wait_cyc(10);
    end
  endtask
  task t_wdog;
    wr_reg(8'h0f, 8'h03, 1'b0);
    wait_cyc(600);
    check(free, 1'b0);
    wr_reg(8'h0f, 8'h02, 1'b0);
    wait_for(0, 700);
    check(n >= 499 && n <= 505, 1'b1);
    hold = 1'b1;
    wait_for(1, 700);
    check(n >= 500 && n <= 512, 1'b1);
    p = 0;
    n = 0;
    // SCL idles high, so a pulse already begun still counts
    last = 1'b1;
    while (recov === 1'b1 && n < 200)
    begin
      if (last === 1'b1 && scl_oe === 1'b0)
        p = p + 1;
      last = scl_oe;
      @(negedge clock_in);
      n = n + 1;
    end
    check(p, 9);
    check({sclo, sdao}, 2'b00);
    hold = 1'b0;
    wr_reg(8'h0f, 8'h01, 1'b0);
    wr_reg(8'h0f, 8'h00, 1'b0);
    wait_for(0, 2100);
    check(n >= 1999 && n <= 2005, 1'b1);
  endtask
  always @(posedge clock_in)
  begin
    cycles = cycles + 1;
    if (cycles == 10000)
    begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  initial
  begin
    repeat (4) @(negedge clock_in);
    rst_b_in = 1'b1;
    t_reset;
    t_pins;
    t_lock;
    t_delay;
    t_wdog;
    final_report;
  end
endmodule

// >>> hw/bus_watchdog.v
`timescale 1ns/10ps
`include "gpio_i2c_cfg_regs.vh"

module bus_watchdog #(
  parameter SLOW_CYC = `WDOG_SLOW_CYC,
  parameter FAST_CYC = `WDOG_FAST_CYC,
  parameter HALF_CYC = `RECOVER_HALF_CYC
) (
  input wire clock_in,
  input wire rst_b_in,
  input wire disable_in,
  input wire fast_in,
  input wire activity_in,
  input wire sda_level_in,
  output reg bus_free_q,
  output reg recovering_q,
  output reg scl_oe_n_q
);

  localparam ST_WATCH = 1'b0;
  localparam ST_RECOVER = 1'b1;
  localparam [3:0] PULSES = `RECOVER_PULSES;

  reg state_q;
  reg [23:0] idle_cnt_q;
  reg [15:0] half_cnt_q;
  reg [3:0] pulse_cnt_q;
  wire [23:0] limit;
  wire expired;

  // ----------------------------------------
  // Idle timer
  // ----------------------------------------
  assign limit = fast_in ? FAST_CYC[23:0] : SLOW_CYC[23:0];
  assign expired = (idle_cnt_q >= limit - 24'h000001);

  always @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      state_q <= ST_WATCH;
      idle_cnt_q <= 24'h000000;
      half_cnt_q <= 16'h0000;
      pulse_cnt_q <= 4'h0;
      bus_free_q <= 1'b0;
      recovering_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
    end
    else
    begin
      case (state_q)
        ST_WATCH:
        begin
          scl_oe_n_q <= 1'b1;
          recovering_q <= 1'b0;
          if (disable_in || activity_in)
          begin
            idle_cnt_q <= 24'h000000;
            bus_free_q <= 1'b0;
          end
          else if (expired)
          begin
            idle_cnt_q <= 24'h000000;
            if (sda_level_in)
              bus_free_q <= 1'b1;
            else
            begin
              state_q <= ST_RECOVER;
              recovering_q <= 1'b1;
              bus_free_q <= 1'b0;
              scl_oe_n_q <= 1'b0;
              half_cnt_q <= 16'h0000;
              pulse_cnt_q <= 4'h0;
            end
          end
          else
            idle_cnt_q <= idle_cnt_q + 24'h000001;
        end
        ST_RECOVER:
        begin
          if (half_cnt_q == HALF_CYC[15:0] - 16'h0001)
          begin
            half_cnt_q <= 16'h0000;
            if (!scl_oe_n_q)
            begin
              scl_oe_n_q <= 1'b1;
              pulse_cnt_q <= pulse_cnt_q + 4'h1;
            end
            else if (pulse_cnt_q == PULSES)
            begin
              state_q <= ST_WATCH;
              recovering_q <= 1'b0;
            end
            else
              scl_oe_n_q <= 1'b0;
          end
          else
            half_cnt_q <= half_cnt_q + 16'h0001;
        end
        default:
        begin
          state_q <= ST_WATCH;
        end
      endcase
    end
  end

endmodule

// >>> hw/gpio_i2c_cfg.v
`timescale 1ns/10ps
`include "gpio_i2c_cfg_regs.vh"

module gpio_i2c_cfg #(
  parameter WDOG_SLOW_CYC = `WDOG_SLOW_CYC,
  parameter RECOVER_HALF_CYC = `RECOVER_HALF_CYC,
  parameter DELAY_TAPS = 8
) (
  input wire clock_in,
  input wire rst_b_in,
  input wire reg_wr_in,
  input wire reg_remote_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  output reg reg_wr_refused_out,
  input wire remote_pin_two_in,
  input wire remote_pin_three_in,
  input wire general_pin_three_in,
  output reg general_pin_two_out,
  output reg general_pin_two_oe_n_out,
  output reg general_pin_three_out,
  output reg general_pin_three_oe_n_out,
  output reg general_pin_three_value_out,
  input wire remote_slave_req_in,
  output reg remote_slave_req_out,
  input wire sda_low_req_in,
  input wire scl_in,
  input wire sda_in,
  output reg scl_out,
  output wire scl_oe_n_out,
  output reg sda_out,
  output reg sda_oe_n_out,
  output wire bus_free_out,
  output wire bus_recovering_out
);

  reg [7:0] gpio_cfg_q;
  reg [7:0] i2c_cfg_q;
  reg [DELAY_TAPS-1:0] sda_line_q;
  wire [1:0] sda_delay_code;
  wire [2:0] sda_tap;
  wire [31:0] sda_tap_full;
  wire wr_hit_gpio;
  wire wr_hit_i2c;
  wire wr_blocked;
  wire activity;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam NSYNC = 5;
  wire [NSYNC-1:0] async_in;
  reg [NSYNC-1:0] meta_q;
  reg [NSYNC-1:0] sync_q;
  reg [1:0] bus_prev_q;

  assign async_in = {remote_pin_two_in, remote_pin_three_in, general_pin_three_in,
                     scl_in, sda_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      always @(posedge clock_in)
      begin
        if (!rst_b_in)
        begin
          meta_q[gi] <= 1'b1;
          sync_q[gi] <= 1'b1;
        end
        else
        begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  wire remote_two_s = sync_q[4];
  wire remote_three_s = sync_q[3];
  wire pin_three_s = sync_q[2];
  wire scl_s = sync_q[1];
  wire sda_s = sync_q[0];

  always @(posedge clock_in)
  begin
    if (!rst_b_in)
      bus_prev_q <= 2'b11;
    else
      bus_prev_q <= {scl_s, sda_s};
  end

  assign activity = (bus_prev_q != {scl_s, sda_s});

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  function is_addr;
    input [7:0] addr;
    input [7:0] target;
    begin
      is_addr = (addr == target);
    end
  endfunction

  assign wr_blocked = reg_remote_in && i2c_cfg_q[`LOCAL_WR_DIS_BIT];
  assign wr_hit_gpio = reg_wr_in && !wr_blocked &&
                       is_addr(reg_addr_in, `GPIO_PAIR_HIGH_CONFIG_ADDR);
  assign wr_hit_i2c = reg_wr_in && !wr_blocked &&
                      is_addr(reg_addr_in, `I2C_HOST_CONFIG_ADDR);

  always @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      gpio_cfg_q <= `GPIO_PAIR_HIGH_CONFIG_RESET;
      i2c_cfg_q <= `I2C_HOST_CONFIG_RESET;
      reg_rdata_out <= 8'h00;
      reg_wr_refused_out <= 1'b0;
    end
    else
    begin
      if (wr_hit_gpio)
        gpio_cfg_q <= reg_wdata_in;
      if (wr_hit_i2c)
        i2c_cfg_q <= reg_wdata_in & `I2C_HOST_CONFIG_MASK;
      reg_wr_refused_out <= reg_wr_in && wr_blocked;
      if (is_addr(reg_addr_in, `GPIO_PAIR_HIGH_CONFIG_ADDR))
        reg_rdata_out <= gpio_cfg_q;
      else if (is_addr(reg_addr_in, `I2C_HOST_CONFIG_ADDR))
        reg_rdata_out <= i2c_cfg_q;
      else
        reg_rdata_out <= 8'h00;
    end
  end

  // Passes remote requests for local I2C slaves regardless of the lock
  always @(posedge clock_in)
  begin
    if (!rst_b_in)
      remote_slave_req_out <= 1'b0;
    else
      remote_slave_req_out <= remote_slave_req_in;
  end

  // ----------------------------------------
  // General purpose pins
  // ----------------------------------------
  always @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      general_pin_two_out <= 1'b0;
      general_pin_two_oe_n_out <= 1'b1;
      general_pin_three_out <= 1'b0;
      general_pin_three_oe_n_out <= 1'b1;
      general_pin_three_value_out <= 1'b0;
    end
    else
    begin
      general_pin_two_oe_n_out <= !gpio_cfg_q[`PIN2_ENABLE_BIT];
      if (gpio_cfg_q[`PIN2_REMOTE_BIT])
        general_pin_two_out <= remote_two_s;
      else
        general_pin_two_out <= gpio_cfg_q[`PIN2_VALUE_BIT];
      if (!gpio_cfg_q[`PIN3_ENABLE_BIT])
        general_pin_three_oe_n_out <= 1'b1;
      else if (gpio_cfg_q[`PIN3_REMOTE_BIT])
        general_pin_three_oe_n_out <= 1'b0;
      else
        general_pin_three_oe_n_out <= gpio_cfg_q[`PIN3_DIR_BIT];
      if (gpio_cfg_q[`PIN3_REMOTE_BIT])
        general_pin_three_out <= remote_three_s;
      else
        general_pin_three_out <= gpio_cfg_q[`PIN3_VALUE_BIT];
      general_pin_three_value_out <= pin_three_s;
    end
  end

  // ----------------------------------------
  // SDA output delay line
  // ----------------------------------------
  assign sda_delay_code = i2c_cfg_q[`SDA_DELAY_HI:`SDA_DELAY_LO];
  // Taps of 350..500 ns at whole clock periods, rounded down
  assign sda_tap_full = (`SDA_DELAY_BASE_NS + `SDA_DELAY_STEP_NS * sda_delay_code)
                        / `CLK_PERIOD_NS - 1;
  assign sda_tap = sda_tap_full[2:0];

  always @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      sda_line_q <= {DELAY_TAPS{1'b0}};
      sda_oe_n_out <= 1'b1;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
    else
    begin
      sda_line_q <= {sda_line_q[DELAY_TAPS-2:0], sda_low_req_in};
      sda_oe_n_out <= !sda_line_q[sda_tap];
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // Bus watchdog
  // ----------------------------------------
  bus_watchdog #(
    .SLOW_CYC(WDOG_SLOW_CYC),
    .FAST_CYC(`WDOG_FAST_CYC),
    .HALF_CYC(RECOVER_HALF_CYC)
  ) u_wdog (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .disable_in(i2c_cfg_q[`WDOG_DIS_BIT]),
    .fast_in(i2c_cfg_q[`WDOG_FAST_BIT]),
    .activity_in(activity),
    .sda_level_in(sda_s),
    .bus_free_q(bus_free_out),
    .recovering_q(bus_recovering_out),
    .scl_oe_n_q(scl_oe_n_out)
  );

endmodule

// >>> hw/gpio_i2c_cfg_regs.vh
// How it works
// - Enabled pin without remote control drives its stored local value as an output, pin three only while its direction bit is 0
// - Enable bit 1 drives pin two (pin three per its remote and direction bits), 0 tri-states the pin; both reset to 1
// - Pin-three remote bit (bit 6, reset 0) outputs the deserializer value
// - Pin-two remote bit (bit 2, reset 1) outputs the deserializer value
// - SDA output delay field adds 50 ns steps, about 350 to 500 ns
// - Local-write-disable bit blocks register writes arriving over the control channel
// - Local-write-disable never blocks remote access to local I2C slaves
// - Speed-up bit makes the watchdog expire after 50 us, else after one second
// - Watchdog-disable bit 1 turns the bus watchdog off
// - SDA high and idle until expiry marks the bus as free
// - SDA low and idle until expiry starts nine SCL clock pulses
`ifndef GPIO_I2C_CFG_REGS_VH
`define GPIO_I2C_CFG_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GPIO_PAIR_HIGH_CONFIG_ADDR 8'h0e
`define I2C_HOST_CONFIG_ADDR 8'h0f

// ----------------------------------------
// gpio_pair_high_config fields
// ----------------------------------------
`define PIN3_VALUE_BIT 7
`define PIN3_REMOTE_BIT 6
`define PIN3_DIR_BIT 5
`define PIN3_ENABLE_BIT 4
`define PIN2_VALUE_BIT 3
`define PIN2_REMOTE_BIT 2
`define PIN2_RSVD_BIT 1
`define PIN2_ENABLE_BIT 0
`define GPIO_PAIR_HIGH_CONFIG_RESET 8'h35

// ----------------------------------------
// i2c_host_config fields
// ----------------------------------------
`define SDA_DELAY_HI 4
`define SDA_DELAY_LO 3
`define LOCAL_WR_DIS_BIT 2
`define WDOG_FAST_BIT 1
`define WDOG_DIS_BIT 0
`define I2C_HOST_CONFIG_MASK 8'h1f
`define I2C_HOST_CONFIG_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define SDA_DELAY_BASE_NS 350
`define SDA_DELAY_STEP_NS 50
`define WDOG_FAST_US 50
`define WDOG_FAST_CYC ((`WDOG_FAST_US * 1000) / `CLK_PERIOD_NS)
`define WDOG_SLOW_S 1
`define WDOG_SLOW_CYC ((`WDOG_SLOW_S * 1000000000) / `CLK_PERIOD_NS)
`define RECOVER_PULSES 9
`define RECOVER_HALF_CYC 50

`endif
